// *** src/lds_pkg.sv ***
/*
 * Package for the LED driver serial write port: frame layout, register map,
 * channel mode encodings and carrier structs.
 * Assumes one system clock domain; the serial pins are asynchronous to it.
 */
package lds_pkg;
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned ADDR_BITS = 8;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned NUM_CHANNELS = 16;
    localparam int unsigned CNT_BITS = 5;
    localparam int unsigned NUM_REGS = 2 * NUM_CHANNELS;

    // Register map: channel n mode at 2n, brightness at 2n+1
    localparam logic [7:0] CH0_MODE_OFFSET = 8'h00;
    localparam logic [7:0] CH0_BRIGHT_OFFSET = 8'h01;
    localparam logic [7:0] REG_STRIDE = 8'h02;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] BRIGHT_RESET = 8'h00;

    // Mode register fields, plus the follow source field of the brightness byte
    localparam int unsigned MODE_MSB = 7;
    localparam int unsigned MODE_LSB = 6;
    localparam int unsigned FOLLOW_INV_BIT = 5;
    localparam int unsigned START_MSB = 4;
    localparam int unsigned START_LSB = 0;
    localparam int unsigned FOLLOW_SRC_MSB = 3;

    typedef enum logic [1:0] {
        MODE_DIRECT = 2'h0,
        MODE_AUDIO = 2'h1,
        MODE_BREATH = 2'h2,
        MODE_FOLLOW = 2'h3
    } lds_mode_type;

    typedef struct packed {
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
    } lds_frame_type;

    typedef struct packed {
        lds_mode_type mode;
        logic follow_inv;
        logic [4:0] start_level;
    } lds_mode_reg_type;
endpackage

// *** src/lds_regfile.sv ***
/*
 * Small register memory of mode and brightness bytes, one write port and one
 * registered read-out of every register on one flat bus.
 * Assumes writes and addresses come already decoded from the frame receiver.
 */
`timescale 1ns/1ps
module lds_regfile
    import lds_pkg::*;
#(
    parameter int unsigned NREGS = NUM_REGS
) (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_b_i, // Async reset, active low
    input wire logic wr_en_i, // Write strobe
    input wire logic [ADDR_BITS-1:0] wr_addr_i, // Write address
    input wire logic [DATA_BITS-1:0] wr_data_i, // Write data
    output logic [NREGS*DATA_BITS-1:0] rd_all_o // All registers, flopped
);
    genvar gi;
    generate
        for (gi = 0; gi < NREGS; gi++) begin : g_reg
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    rd_all_o[gi*DATA_BITS +: DATA_BITS] <= (gi % 2 == 0) ? MODE_RESET : BRIGHT_RESET;
                end else if (wr_en_i && wr_addr_i == ADDR_BITS'(gi)) begin
                    rd_all_o[gi*DATA_BITS +: DATA_BITS] <= wr_data_i;
                end
            end
        end
    endgenerate
endmodule

// *** src/lds_serial_port.sv ***
/*
 * Write-only three-wire serial port of a 16-channel LED driver, with the
 * channel registers and a per-channel output level derived from the mode.
 * Assumes the serial pins are asynchronous and far slower than clk_sys_i.
 */
`timescale 1ns/1ps
module lds_serial_port
    import lds_pkg::*;
#(
    parameter int unsigned NCH = NUM_CHANNELS
) (
    input wire logic clk_sys_i, // System clock, 25 MHz
    input wire logic rst_b_i, // Async reset, active low
    input wire logic ser_clk_pin_i, // Serial clock pin
    input wire logic ser_din_pin_i, // Serial data pin
    input wire logic ser_select_n_i, // Serial select, active low
    input wire logic [7:0] audio_level_i, // Audio strength, clk_sys_i domain
    output logic [NCH*8-1:0] led_level_o, // Per-channel brightness level
    output lds_mode_reg_type led_channel_zero_mode_o, // Channel 0 mode register
    output logic frame_done_o // One-cycle pulse per accepted frame
);
    typedef enum logic [2:0] {
        RX_IDLE = 3'h1,
        RX_SHIFT = 3'h2,
        RX_HOLD = 3'h4
    } lds_rx_state_type;

    logic [2:0] clk_sync_reg;
    logic [1:0] din_sync_reg;
    logic [1:0] sel_sync_reg;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [CNT_BITS-1:0] count_reg;
    lds_rx_state_type rx_state_reg;
    logic wr_en_reg;
    lds_frame_type frame_reg;
    logic [NUM_REGS*8-1:0] regs_all;
    logic [NCH*8-1:0] base_level;
    logic clk_rise;
    logic sel_active;
    logic shift_en;
    logic bit_last;
    logic [FRAME_BITS-1:0] shift_in;

    // Serial clock: two sync stages plus a third used only for edge finding
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_sync_reg <= 3'h0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[1:0], ser_clk_pin_i};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            din_sync_reg <= 2'h0;
        end else begin
            din_sync_reg <= {din_sync_reg[0], ser_din_pin_i};
        end
    end

    // Select idles high, so its synchroniser resets high
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sel_sync_reg <= 2'h3;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], ser_select_n_i};
        end
    end

    // One-cycle enable per serial clock rise; data is delayed alike
    assign clk_rise = clk_sync_reg[1] && !clk_sync_reg[2];
    assign sel_active = !sel_sync_reg[1];
    assign shift_en = sel_active && clk_rise && rx_state_reg != RX_HOLD;
    assign bit_last = shift_en && count_reg == CNT_BITS'(FRAME_BITS - 1);
    assign shift_in = {shift_reg[FRAME_BITS-2:0], din_sync_reg[1]};

    // Frame progress: clocks after the sixteenth bit are ignored in hold
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_state_reg <= RX_IDLE;
        end else begin
            case (rx_state_reg)
                RX_IDLE: begin
                    if (sel_active) begin
                        rx_state_reg <= RX_SHIFT;
                    end
                end
                RX_SHIFT: begin
                    if (!sel_active) begin
                        rx_state_reg <= RX_IDLE;
                    end else if (bit_last) begin
                        rx_state_reg <= RX_HOLD;
                    end
                end
                RX_HOLD: begin
                    if (!sel_active) begin
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    // Shift in MSB first on serial clock rise while selected
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_reg <= 16'h0000;
        end else if (shift_en) begin
            shift_reg <= shift_in;
        end
    end

    // Count restarts while select is high, so a cut frame is lost
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_reg <= 5'h00;
        end else if (!sel_active) begin
            count_reg <= 5'h00;
        end else if (shift_en) begin
            count_reg <= count_reg + 5'h01;
        end
    end

    // Write strobe follows the sixteenth bit by one cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_en_reg <= 1'b0;
        end else begin
            wr_en_reg <= bit_last;
        end
    end

    // First eight bits become the address, the last eight the data
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_reg <= '0;
        end else if (bit_last) begin
            frame_reg <= shift_in;
        end
    end

    lds_regfile #(
        .NREGS(NUM_REGS)
    ) u_regs (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .wr_en_i(wr_en_reg),
        .wr_addr_i(frame_reg.addr),
        .wr_data_i(frame_reg.data),
        .rd_all_o(regs_all)
    );

    // First pass: levels of channels not in follow mode
    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++) begin : g_base
            lds_mode_reg_type m;
            logic [7:0] b;
            logic [3:0] src;
            logic [7:0] src_level;
            assign m = regs_all[(2*gc)*8 +: 8];
            assign b = regs_all[(2*gc+1)*8 +: 8];
            assign src = b[FOLLOW_SRC_MSB:0];
            assign src_level = base_level[src*8 +: 8];
            always_comb begin
                case (m.mode)
                    MODE_DIRECT: base_level[gc*8 +: 8] = b;
                    MODE_AUDIO: base_level[gc*8 +: 8] = audio_level_i;
                    MODE_BREATH: base_level[gc*8 +: 8] = {m.start_level, m.start_level[4:2]};
                    default: base_level[gc*8 +: 8] = 8'h00;
                endcase
            end
            // Follow reads the source's base level, so no loops can form
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    led_level_o[gc*8 +: 8] <= 8'h00;
                end else if (m.mode == MODE_FOLLOW && m.follow_inv) begin
                    led_level_o[gc*8 +: 8] <= ~src_level;
                end else if (m.mode == MODE_FOLLOW) begin
                    led_level_o[gc*8 +: 8] <= src_level;
                end else begin
                    led_level_o[gc*8 +: 8] <= base_level[gc*8 +: 8];
                end
            end
        end
    endgenerate

    // Copy of the channel 0 mode register, one cycle after the write
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            led_channel_zero_mode_o <= MODE_RESET;
        end else begin
            led_channel_zero_mode_o <= regs_all[CH0_MODE_OFFSET*8 +: 8];
        end
    end

    // Completion pulse: the only status the port reports besides the channel 0 mode copy
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_done_o <= 1'b0;
        end else begin
            frame_done_o <= wr_en_reg;
        end
    end
endmodule

// *** tb/lds_host_model.sv ***
/* Serial controller model that writes frames; tb calls send, one frame at a time.
 * Paces its pins from the bench clock: four clocks per half period of the link. */
`timescale 1ns/1ps
module lds_host_model (
    input wire logic clk_sys_i, // Bench clock
    output logic ser_clk_pin_o, // Clock
    output logic ser_din_pin_o, // Data
    output logic ser_select_n_o // Select
);
    initial begin
        ser_clk_pin_o = 1'b0;
        ser_select_n_o = 1'b1;
        ser_din_pin_o = 1'b0;
    end
    // Fewer than 16 bits cuts the frame short
    task automatic send(input logic [15:0] f, input int nbits);
        @(posedge clk_sys_i);
        ser_select_n_o <= 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            ser_din_pin_o <= f[i];
            repeat (4) @(posedge clk_sys_i);
            ser_clk_pin_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            ser_clk_pin_o <= 1'b0;
        end
        @(posedge clk_sys_i);
        ser_din_pin_o <= ~ser_din_pin_o;
        repeat (3) @(posedge clk_sys_i);
        ser_select_n_o <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
    endtask
endmodule

// *** tb/lds_serial_port_properties.sv ***
/* Checker for lds_serial_port; bound to it, sees its ports only. */
`timescale 1ns/1ps
module lds_serial_port_properties import lds_pkg::*; #(parameter int unsigned NCH = NUM_CHANNELS) (
    input wire logic clk_sys_i, // Clock
    input wire logic rst_b_i, // Reset
    input wire logic ser_select_n_i, // Select
    input wire logic [7:0] audio_level_i, // Audio
    input wire logic [NCH*8-1:0] led_level_o, // Levels
    input wire lds_mode_reg_type led_channel_zero_mode_o, // Mode
    input wire logic frame_done_o // Done
);
    wire lds_mode_reg_type md = led_channel_zero_mode_o;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    property p_gap; frame_done_o |=> !frame_done_o [*8]; endproperty
    a_gap: assert property (p_gap) else $error("done too close");
    property p_sel; frame_done_o |-> !ser_select_n_i; endproperty
    a_sel: assert property (p_sel) else $error("done off frame");
    property p_idle; ser_select_n_i [*8] |-> !frame_done_o; endproperty
    a_idle: assert property (p_idle) else $error("late done");
    property p_mode; $changed(md) |-> $past(frame_done_o); endproperty
    a_mode: assert property (p_mode) else $error("mode moved");
    property p_lvl; $changed(led_level_o) |-> $past(frame_done_o); endproperty
    a_lvl: assert property (p_lvl) else $error("level moved");
    property p_br;
        md.mode == MODE_BREATH && $stable(md) |-> led_level_o[7:0] == {md.start_level, md.start_level[4:2]};
    endproperty
    a_br: assert property (p_br) else $error("breath level");
    property p_au; md.mode == MODE_AUDIO && $stable(md) |-> led_level_o[7:0] == audio_level_i; endproperty
    a_au: assert property (p_au) else $error("audio level");
    property p_rst; $rose(rst_b_i) |-> md == 8'h00 && led_level_o == '0; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    c_done: cover property (frame_done_o);
    c_br: cover property (md.mode == MODE_BREATH);
    c_au: cover property (md.mode == MODE_AUDIO);
endmodule
bind lds_serial_port lds_serial_port_properties #(.NCH(NCH)) i_lds_serial_port_properties (.*);

// *** tb/tb.sv ***
/* Bench for lds_serial_port; lds_host_model drives the serial pins. */
`timescale 1ns/1ps
module tb;
    import lds_pkg::*;
    typedef struct packed {logic [15:0] f; logic [3:0] c; logic [7:0] m; logic [7:0] v;} lds_row_type;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, ser_clk_pin_i, ser_din_pin_i, ser_select_n_i, frame_done_o;
    logic [7:0] audio_level_i = 8'h37;
    logic [127:0] led_level_o;
    lds_mode_reg_type led_channel_zero_mode_o;
    int err_count = 0, check_count = 0, cycles = 0, dones = 0;
    lds_row_type rows [7] = '{36'h015a0005a, 36'h00930939c, 36'h004004037, 36'h02c014037,
        36'h00000005a, 36'h02e0100a5, 36'h1f77f0077};
    always #20 clk_sys_i = ~clk_sys_i;
    lds_host_model i_lds_host_model (.clk_sys_i(clk_sys_i), .ser_clk_pin_o(ser_clk_pin_i),
        .ser_din_pin_o(ser_din_pin_i), .ser_select_n_o(ser_select_n_i));
    lds_serial_port i_lds_serial_port (.*);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) err_count++;
        if (seen !== exp) $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (frame_done_o === 1'b1) dones <= dones + 1;
        if (cycles == 2000) err_count++;
        if (cycles == 2000) close_out();
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        foreach (rows[r]) begin
            i_lds_host_model.send(rows[r].f, 16);
            @(negedge clk_sys_i);
            chk(8'(dones), 8'(r + 1));
            chk(led_channel_zero_mode_o, rows[r].m);
            chk(led_level_o[8*rows[r].c +: 8], rows[r].v);
        end
        i_lds_host_model.send(16'h00c0, 15);
        @(negedge clk_sys_i);
        chk(8'(dones), 8'h07);
        chk(led_channel_zero_mode_o, 8'h00);
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(led_level_o[127:120], 8'h00);
        chk(led_level_o[15:8], 8'h00);
        @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        i_lds_host_model.send(16'h1e9f, 16);
        @(negedge clk_sys_i);
        chk(8'(dones), 8'h08);
        chk(led_level_o[127:120], 8'hff);
        close_out();
    end
endmodule
